// >>> include/crb_out_if.sv
// Interface: array side to output register stage
`timescale 1ns/100ps
interface crb_out_if #(parameter int W = 36);
	logic         ce;     // Clock enable
	logic [W-1:0] a_next; // Port A array word, bypass path
	logic [W-1:0] a_reg;  // Port A array word, pipelined path
	logic [W-1:0] b_next; // Port B array word, bypass path
	logic [W-1:0] b_reg;  // Port B array word, pipelined path
	logic         a_oreg; // Port A output register in use
	logic         b_oreg; // Port B output register in use
	logic [W-1:0] qa;     // Port A block output
	logic [W-1:0] qb;     // Port B block output
	modport core  (output ce, a_next, a_reg, b_next, b_reg, a_oreg, b_oreg,
		input qa, qb);
	modport stage (input ce, a_next, a_reg, b_next, b_reg, a_oreg, b_oreg,
		output qa, qb);
endinterface

// >>> include/crb_pkg.sv
// Package: constants and types of the configurable embedded RAM block
// Function
// [R1] Three sizes: 32x18, 128x36, 4Kx144 bits.
// [R2] Medium/large true dual-port: any two operations.
// [R3] Simple dual-port: read and write together.
// [R4] Single-port write shows written word on output.
// [R5] All block inputs pass input registers.
// [R6] Write strobe is self-timed from clock.
// [R7] Optional output register adds one cycle.
// [R8] Flow-through read bypasses read input registers.
// [R9] Ports may differ in width over storage.
// [R10] Medium block hosts two half-size single ports.
// [R11] Input clear acts now, shows next edge.
// [R12] Output clear shows on output at once.
// [R13] Large block clears only output registers.
// [R14] Each byte carries a ninth user bit.
// [R15] Byte enables keep unselected lanes unchanged.
// [R16] User logic loads large-block ROM by writing.
// [R17] Small block write registers share one clock.
// [R18] Narrow port address selects sub-word, low first.
// [R19] User avoids same-address double writes.
package crb_pkg;
	// Block size and operating mode
	typedef enum logic [1:0] {CRB_SMALL, CRB_MEDIUM, CRB_LARGE}
		crb_kind_type;
	typedef enum logic [1:0] {CRB_SINGLE, CRB_SDP, CRB_TDP, CRB_SPLIT}
		crb_mode_type;
	// Native organisations
	localparam int SMALL_WIDTH  = 18;
	localparam int SMALL_DEPTH  = 32;
	localparam int MEDIUM_WIDTH = 36;
	localparam int MEDIUM_DEPTH = 128;
	localparam int LARGE_WIDTH  = 144;
	localparam int LARGE_DEPTH  = 4096;
	localparam int LANE_BITS    = 9;   // Eight data bits plus one user bit
	localparam int SHIFT_MAX    = 3;   // Port width codes: W, W/2, W/4, W/8
	localparam int SHIFT_BITS   = 2;
	localparam int SEL_BITS     = 3;
	localparam int MODE_BITS    = 2;
	localparam int KIND_BITS    = 2;
	// Register bus
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 32;
	localparam logic [BUS_AW-1:0] REG_CTRL   = 4'h0;
	localparam logic [BUS_AW-1:0] REG_STATUS = 4'h4;
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_OREG_A    = 2;
	localparam int CTRL_OREG_B    = 3;
	localparam int CTRL_FLOW      = 4;
	localparam int CTRL_WID_A_LSB = 5;
	localparam int CTRL_WID_B_LSB = 7;
	localparam int STAT_COLL      = 0;
	localparam int STAT_REFUSED   = 1;
	localparam int STAT_KIND_LSB  = 2;
	// Fill bit driven for an undefined read-during-write
	localparam logic RDW_UNDEF = 1'b1;

	// Native word width of a block kind
	function automatic int crb_width(crb_kind_type k);
		case (k)
			CRB_SMALL: return SMALL_WIDTH;
			CRB_LARGE: return LARGE_WIDTH;
			default:   return MEDIUM_WIDTH;
		endcase
	endfunction

	// Native depth of a block kind
	function automatic int crb_depth(crb_kind_type k);
		case (k)
			CRB_SMALL: return SMALL_DEPTH;
			CRB_LARGE: return LARGE_DEPTH;
			default:   return MEDIUM_DEPTH;
		endcase
	endfunction
endpackage

// >>> src/crb_out_stage.sv
// Output register stage with its own asynchronous clear
`timescale 1ns/100ps
module crb_out_stage
	import crb_pkg::*;
#(
	parameter int W = 36
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic oclr_i,
	crb_out_if.stage  io
);
	typedef struct packed {
		logic [W-1:0] qa;
		logic [W-1:0] qb;
	} crb_ostate_type;

	crb_ostate_type q;       // Output registers
	crb_ostate_type n;       // Their next value
	logic           orst_n;  // Combined reset and output clear

	// Output clear hits every block kind and takes effect at once
	assign orst_n = resetn_i & ~oclr_i; // see [R12] see [R13]

	// Bypass loads what the array latch loads now; else one stage later
	always_comb begin
		n = q;
		if (io.ce) begin
			n.qa = io.a_oreg ? io.a_reg : io.a_next; // see [R7]
			n.qb = io.b_oreg ? io.b_reg : io.b_next; // see [R7]
		end
	end

	// Register the stage
	always_ff @(posedge clk_i or negedge orst_n) begin
		if (!orst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign io.qa = q.qa;
	assign io.qb = q.qb;
endmodule

// >>> src/crb_ram_block.sv
// Configurable embedded RAM block: ports, array, control registers
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module crb_ram_block
	import crb_pkg::*;
#(
	parameter crb_kind_type KIND = CRB_MEDIUM,
	localparam int W  = crb_width(KIND), // see [R1]
	localparam int D  = crb_depth(KIND),
	localparam int DA = $clog2(D),
	localparam int AW = DA + SHIFT_MAX,
	localparam int NB = W / LANE_BITS
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	input  wire logic              iclr_i,
	input  wire logic              oclr_i,
	input  wire logic [AW-1:0]     a_addr_i,
	input  wire logic [W-1:0]      a_wdata_i,
	input  wire logic [NB-1:0]     a_be_i,
	input  wire logic              a_we_i,
	input  wire logic              a_re_i,
	input  wire logic [AW-1:0]     b_addr_i,
	input  wire logic [W-1:0]      b_wdata_i,
	input  wire logic [NB-1:0]     b_be_i,
	input  wire logic              b_we_i,
	input  wire logic              b_re_i,
	output logic [W-1:0]           q_a_o,
	output logic [W-1:0]           q_b_o,
	input  wire logic [BUS_AW-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [BUS_DW-1:0] avs_writedata_i,
	output logic [BUS_DW-1:0]      avs_readdata_o,
	output logic                   avs_waitrequest_o
);
	// One port's input register set
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [W-1:0]  wd;
		logic [NB-1:0] be;
		logic          we;
		logic          re;
	} crb_port_type;

	// Input registers, cleared by the input clear on the small and medium sizes
	typedef struct packed {
		crb_port_type a;
		crb_port_type b;
	} crb_in_type;

	// Array, array latches, control and bus state
	typedef struct packed {
		logic [D-1:0][W-1:0]   mem;
		logic [W-1:0]          aq_a;
		logic [W-1:0]          aq_b;
		logic [MODE_BITS-1:0]  mode;
		logic                  oreg_a;
		logic                  oreg_b;
		logic                  flow;
		logic [SHIFT_BITS-1:0] wid_a;
		logic [SHIFT_BITS-1:0] wid_b;
		logic                  coll;
		logic                  refused;
		logic                  wait_r;
		logic [BUS_DW-1:0]     rdata;
	} crb_core_type;

	localparam logic [DA-1:0] IDX_TOP = DA'(1) << (DA - 1);
	localparam logic CLR_INPUTS = (KIND != CRB_LARGE);

	crb_in_type   qi;       // Input registers
	crb_in_type   ni;       // Their next value
	crb_core_type q;        // Core state
	crb_core_type n;        // Its next value
	logic         in_rst_n; // Reset or input clear
	crb_mode_type m_req;    // Mode asked for by software
	crb_mode_type mode_e;   // Mode in force
	logic         refuse;   // Asked mode not offered by this size
	logic         flow;     // Flow-through read in force
	logic [AW-1:0] rb_addr; // Read address of port B
	logic          rb_re;   // Read enable of port B
	logic [DA-1:0] idx_a;   // Native word of port A
	logic [DA-1:0] idx_b;   // Native word of port B
	logic [SEL_BITS-1:0] sel_a; // Sub-word of port A
	logic [SEL_BITS-1:0] sel_b; // Sub-word of port B
	logic          wr_a;    // Port A writes this cycle
	logic          wr_b;    // Port B writes this cycle
	logic          rd_a;    // Port A reads this cycle
	logic          rd_b;    // Port B reads this cycle
	logic          rdw_b;   // Undefined read-during-write on B
	logic          coll;    // Both ports write one word
	logic [W-1:0]  new_a;   // Word after port A write
	logic [W-1:0]  new_b;   // Word after port B write
	logic [W-1:0]  thru_a;  // Sub-word written by port A
	logic [W-1:0]  lane0_a; // Old low lane at port A word
	logic          req;     // Bus request present
	crb_out_if #(.W(W)) oif ();

	// Byte-lane mask placed on the addressed sub-word
	function automatic logic [W-1:0] f_mask(logic [SHIFT_BITS-1:0] k,
		logic [SEL_BITS-1:0] s, logic [NB-1:0] be);
		logic [W-1:0] lanes;
		int           sw;
		lanes = '0;
		sw = W >> k;
		for (int i = 0; i < NB; i++) begin
			lanes[i*LANE_BITS +: LANE_BITS] = {LANE_BITS{be[i]}}; // see [R14]
		end
		return (lanes & ({W{1'b1}} >> (W - sw))) << (int'(s) * sw);
	endfunction

	// Merge a narrow write into a native word
	function automatic logic [W-1:0] f_merge(logic [W-1:0] old,
		logic [SHIFT_BITS-1:0] k, logic [SEL_BITS-1:0] s,
		logic [W-1:0] wd, logic [NB-1:0] be);
		logic [W-1:0] m;
		m = f_mask(k, s, be);
		return (old & ~m) | ((wd << (int'(s) * (W >> k))) & m); // see [R15]
	endfunction

	// Pick the addressed sub-word, low address bits select low part
	function automatic logic [W-1:0] f_get(logic [W-1:0] word,
		logic [SHIFT_BITS-1:0] k, logic [SEL_BITS-1:0] s);
		return (word >> (int'(s) * (W >> k))) & ({W{1'b1}} >> (W - (W >> k)));
	endfunction

	// Native index: the port address bits above the sub-word select
	function automatic logic [DA-1:0] f_idx(logic [AW-1:0] a,
		logic [SHIFT_BITS-1:0] k);
		return DA'(a >> k); // see [R18]
	endfunction

	// Sub-word select: the low k address bits
	function automatic logic [SEL_BITS-1:0] f_sel(logic [AW-1:0] a,
		logic [SHIFT_BITS-1:0] k);
		return a[SEL_BITS-1:0] & ~({SEL_BITS{1'b1}} << k); // see [R18]
	endfunction

	// Mode decode; a mode the size lacks falls back to simple dual-port
	assign m_req  = crb_mode_type'(q.mode);
	assign refuse = (m_req == CRB_TDP && KIND == CRB_SMALL) || // see [R2] see [R9]
		(m_req == CRB_SPLIT && KIND != CRB_MEDIUM); // see [R10]
	assign mode_e = refuse ? CRB_SDP : m_req;
	assign flow   = q.flow && mode_e == CRB_SDP && KIND != CRB_LARGE;

	// Flow-through: read side taken straight from the pins, standing in
	// for a falling-edge capture half a cycle ahead of the array
	assign rb_addr = flow ? b_addr_i : qi.b.addr; // see [R8]
	assign rb_re   = flow ? b_re_i : qi.b.re; // see [R8]

	// Split mode pins port A to the low half and port B to the high one
	assign idx_a = f_idx(qi.a.addr, q.wid_a) &
		~((mode_e == CRB_SPLIT) ? IDX_TOP : '0); // see [R10]
	assign idx_b = f_idx(rb_addr, q.wid_b) |
		((mode_e == CRB_SPLIT) ? IDX_TOP : '0); // see [R10]
	assign sel_a = f_sel(qi.a.addr, q.wid_a);
	assign sel_b = f_sel(rb_addr, q.wid_b);

	// Operations from registered controls, save the flow-through read of port B from the pins: strobe is the clock itself
	assign wr_a = qi.a.we; // see [R6]
	assign wr_b = qi.b.we && (mode_e == CRB_TDP || mode_e == CRB_SPLIT);
	assign rd_a = qi.a.re && mode_e != CRB_SDP; // see [R4]
	assign rd_b = rb_re && mode_e != CRB_SINGLE; // see [R3]
	assign rdw_b = KIND == CRB_LARGE && mode_e == CRB_SDP && wr_a && rd_b &&
		idx_a == idx_b; // see [R3]
	assign coll = mode_e == CRB_TDP && wr_a && wr_b && idx_a == idx_b;
	assign new_a   = f_merge(q.mem[idx_a], q.wid_a, sel_a, qi.a.wd, qi.a.be);
	assign new_b   = f_merge(q.mem[idx_b], q.wid_b, sel_b, qi.b.wd, qi.b.be);
	assign thru_a  = f_get(new_a, q.wid_a, sel_a);
	assign lane0_a = W'(q.mem[idx_a][LANE_BITS-1:0]);
	assign req     = avs_read_i | avs_write_i;

	// Input clear only exists on the small and medium sizes
	assign in_rst_n = resetn_i & ~(iclr_i & CLR_INPUTS); // see [R11] see [R13]

	// Next state of inputs, array, control and bus slave
	always_comb begin
		logic [BUS_DW-1:0] img;
		img = '0;
		n = q;
		ni = qi;
		if (ce_i) begin
			// Capture every port input; small size has no byte enables
			// and one clock for all its write registers
			ni.a.addr = a_addr_i; // see [R5] see [R17]
			ni.a.wd   = a_wdata_i;
			ni.a.be   = (KIND == CRB_SMALL) ? '1 : a_be_i; // see [R15]
			ni.a.we   = a_we_i;
			ni.a.re   = a_re_i;
			ni.b.addr = b_addr_i; // see [R5]
			ni.b.wd   = b_wdata_i;
			ni.b.be   = (KIND == CRB_SMALL) ? '1 : b_be_i;
			ni.b.we   = b_we_i;
			ni.b.re   = b_re_i;
			// Array writes; B lands last, so on a collision B's word is kept
			if (wr_a) begin
				n.mem[idx_a] = new_a;
			end
			if (wr_b) begin
				n.mem[idx_b] = new_b; // see [R2] see [R19]
			end
			// Port A latch: written word passes through except in simple dual-port, else a read
			if (wr_a && mode_e != CRB_SDP) begin
				n.aq_a = thru_a; // see [R4]
			end else if (rd_a) begin
				n.aq_a = f_get(q.mem[idx_a], q.wid_a, sel_a);
			end
			// Port B latch: written word, else old data, or fill for the large size in simple dual-port
			if (wr_b) begin
				n.aq_b = f_get(new_b, q.wid_b, sel_b);
			end else if (rdw_b) begin
				n.aq_b = {W{RDW_UNDEF}}; // see [R3]
			end else if (rd_b) begin
				n.aq_b = f_get(q.mem[idx_b], q.wid_b, sel_b); // see [R9]
			end
			// Bus slave: answer one cycle after the request is seen
			n.wait_r = 1'b1;
			if (req && q.wait_r) begin
				n.wait_r = 1'b0;
				n.rdata = '0;
				case (avs_address_i)
					REG_CTRL: begin
						img[CTRL_MODE_LSB +: MODE_BITS] = q.mode;
						img[CTRL_OREG_A] = q.oreg_a;
						img[CTRL_OREG_B] = q.oreg_b;
						img[CTRL_FLOW] = q.flow;
						img[CTRL_WID_A_LSB +: SHIFT_BITS] = q.wid_a;
						img[CTRL_WID_B_LSB +: SHIFT_BITS] = q.wid_b;
						if (avs_write_i) begin
							n.mode = avs_writedata_i[CTRL_MODE_LSB +: MODE_BITS];
							n.oreg_a = avs_writedata_i[CTRL_OREG_A]; // see [R7]
							n.oreg_b = avs_writedata_i[CTRL_OREG_B];
							n.flow = avs_writedata_i[CTRL_FLOW];
							n.wid_a = avs_writedata_i[CTRL_WID_A_LSB +: SHIFT_BITS];
							n.wid_b = avs_writedata_i[CTRL_WID_B_LSB +: SHIFT_BITS];
						end
					end
					REG_STATUS: begin
						img[STAT_COLL] = q.coll;
						img[STAT_REFUSED] = q.refused;
						img[STAT_KIND_LSB +: KIND_BITS] = KIND;
						// Write one to clear
						if (avs_write_i && avs_writedata_i[STAT_COLL]) begin
							n.coll = 1'b0;
						end
						if (avs_write_i && avs_writedata_i[STAT_REFUSED]) begin
							n.refused = 1'b0;
						end
					end
					default: begin
						img = '0;
					end
				endcase
				if (avs_read_i) begin
					n.rdata = img;
				end
			end
			// A new event beats a clear in the same cycle
			if (coll) begin
				n.coll = 1'b1;
			end
			if (refuse) begin
				n.refused = 1'b1;
			end
		end
	end

	// Input registers carry their own clear
	always_ff @(posedge clk_i or negedge in_rst_n) begin
		if (!in_rst_n) begin
			qi <= '0;
		end else begin
			qi <= ni;
		end
	end

	// Core registers; bus idles with waitrequest high
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.wait_r <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// Output stage feeds
	assign oif.ce     = ce_i;
	assign oif.a_next = n.aq_a;
	assign oif.a_reg  = q.aq_a;
	assign oif.b_next = n.aq_b;
	assign oif.b_reg  = q.aq_b;
	assign oif.a_oreg = q.oreg_a;
	assign oif.b_oreg = q.oreg_b && !flow; // see [R8]

	// Output registers with the output clear
	crb_out_stage #(.W(W)) u_out (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.oclr_i   (oclr_i),
		.io       (oif.stage)
	);

	assign q_a_o             = oif.qa;
	assign q_b_o             = oif.qb;
	assign avs_readdata_o    = q.rdata;
	assign avs_waitrequest_o = q.wait_r;

	// Checks of the documented behaviour
	a_in_capture: assert property ( // see [R5]
		@(posedge clk_i) disable iff (!in_rst_n)
		ce_i && a_we_i |=> qi.a.we)
		else $error("port A write not captured");
	a_thru_word: assert property ( // see [R4]
		@(posedge clk_i) disable iff (!resetn_i || oclr_i)
		ce_i && mode_e == CRB_SINGLE && wr_a && !q.oreg_a
		|=> q_a_o == $past(thru_a))
		else $error("written word not on output");
	a_oreg_delay: assert property ( // see [R7]
		@(posedge clk_i) disable iff (!resetn_i || oclr_i)
		ce_i && q.oreg_a |=> q_a_o == $past(q.aq_a))
		else $error("output register latency wrong");
	a_in_clear: assert property ( // see [R11]
		@(posedge clk_i) disable iff (!resetn_i)
		iclr_i && CLR_INPUTS |-> !qi.a.we && !qi.b.we)
		else $error("input clear missed");
	a_out_clear: assert property ( // see [R12]
		@(posedge clk_i) disable iff (!resetn_i)
		oclr_i |-> q_a_o == '0 && q_b_o == '0)
		else $error("output clear not immediate");
	a_large_keep: assert property ( // see [R13]
		@(posedge clk_i) disable iff (!resetn_i)
		KIND == CRB_LARGE && ce_i && b_re_i |=> qi.b.re)
		else $error("large block input cleared");
	a_rdw_fill: assert property ( // see [R3]
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && rdw_b |=> q.aq_b == {W{RDW_UNDEF}})
		else $error("large read-during-write not filled");
	a_tdp_two: assert property ( // see [R2]
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && wr_a && wr_b && mode_e == CRB_TDP && idx_a != idx_b
		|=> q.mem[$past(idx_a)] == $past(new_a) &&
			q.mem[$past(idx_b)] == $past(new_b))
		else $error("dual write lost");
	a_byte_keep: assert property ( // see [R15]
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && wr_a && !wr_b && q.wid_a == '0 && !qi.a.be[0]
		|=> W'(q.mem[$past(idx_a)][LANE_BITS-1:0]) == $past(lane0_a))
		else $error("disabled byte lane changed");
	a_bus_answer: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		ce_i && req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");
endmodule

// >>> verif/crb_fabric_model.sv
// Fabric user logic model that drives both data ports of the RAM block
`timescale 1ns/100ps
module crb_fabric_model
	import crb_pkg::*;
#(
	parameter int W  = 36,
	parameter int AW = 10,
	parameter int NB = 4
) (
	input  wire logic     clk_i,
	output logic [AW-1:0] a_addr_o,
	output logic [W-1:0]  a_wdata_o,
	output logic [NB-1:0] a_be_o,
	output logic          a_we_o,
	output logic          a_re_o,
	output logic [AW-1:0] b_addr_o,
	output logic [W-1:0]  b_wdata_o,
	output logic [NB-1:0] b_be_o,
	output logic          b_we_o,
	output logic          b_re_o
);
	// Quiet lines at time zero
	initial begin
		{a_addr_o, a_wdata_o, a_be_o, a_we_o, a_re_o} = '0;
		{b_addr_o, b_wdata_o, b_be_o, b_we_o, b_re_o} = '0;
	end

	// One transfer on both ports, held across exactly one capture edge.
	// Callers never write one word from both ports at once
	task automatic op(input logic awe, are, input logic [AW-1:0] aad,
		input logic [W-1:0] ad, input logic [NB-1:0] abe,
		input logic bwe, bre, input logic [AW-1:0] bad,
		input logic [W-1:0] bd);
		@(posedge clk_i);
		a_we_o    <= awe;
		a_re_o    <= are;
		a_addr_o  <= aad;
		a_wdata_o <= ad;
		a_be_o    <= abe;
		b_we_o    <= bwe;
		b_re_o    <= bre;
		b_addr_o  <= bad;
		b_wdata_o <= bd;
		b_be_o    <= '1;
		@(posedge clk_i);
		// Enables drop and stay low until the next call
		a_we_o    <= 1'h0;
		a_re_o    <= 1'h0;
		b_we_o    <= 1'h0;
		b_re_o    <= 1'h0;
		// Released lines show the inverse, so a stale copy cannot pass
		a_addr_o  <= ~aad;
		a_wdata_o <= ~ad;
		b_addr_o  <= ~bad;
		b_wdata_o <= ~bd;
	endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the medium RAM block
`timescale 1ns/100ps
module tb
	import crb_pkg::*;
();
	localparam int W  = MEDIUM_WIDTH;
	localparam int AW = $clog2(MEDIUM_DEPTH) + SHIFT_MAX;
	localparam int NB = W / LANE_BITS;
	localparam logic [W-1:0] D5 = 36'h1_2345_6789; // Word 5 contents
	localparam logic [W-1:0] D6 = 36'h9_8765_4321; // Word 6 contents
	localparam logic [W-1:0] DA = 36'h5_a5a5_a5a5; // Port A test word
	localparam logic [W-1:0] DB = 36'ha_5a5a_5a5a; // Port B test word

	logic              clk_i, resetn_i, ce_i, iclr_i, oclr_i;
	logic [AW-1:0]     a_addr_i, b_addr_i;
	logic [W-1:0]      a_wdata_i, b_wdata_i, q_a_o, q_b_o, exp6;
	logic [NB-1:0]     a_be_i, b_be_i;
	logic              a_we_i, a_re_i, b_we_i, b_re_i;
	logic [BUS_AW-1:0] avs_address_i;
	logic              avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [BUS_DW-1:0] avs_writedata_i, avs_readdata_o, rd;
	int                n_mismatch, samples_checked;

	crb_ram_block #(.KIND(CRB_MEDIUM)) dut (.clk_i(clk_i),
		.resetn_i(resetn_i), .ce_i(ce_i), .iclr_i(iclr_i), .oclr_i(oclr_i),
		.a_addr_i(a_addr_i), .a_wdata_i(a_wdata_i), .a_be_i(a_be_i),
		.a_we_i(a_we_i), .a_re_i(a_re_i), .b_addr_i(b_addr_i),
		.b_wdata_i(b_wdata_i), .b_be_i(b_be_i), .b_we_i(b_we_i),
		.b_re_i(b_re_i), .q_a_o(q_a_o), .q_b_o(q_b_o),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o));

	crb_fabric_model #(.W(W), .AW(AW), .NB(NB)) fab (.clk_i(clk_i),
		.a_addr_o(a_addr_i), .a_wdata_o(a_wdata_i), .a_be_o(a_be_i),
		.a_we_o(a_we_i), .a_re_o(a_re_i), .b_addr_o(b_addr_i),
		.b_wdata_o(b_wdata_i), .b_be_o(b_be_i), .b_we_o(b_we_i),
		.b_re_o(b_re_i));

	// 40 MHz clock
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Compare and count; unknown never matches
	task automatic check(input string name, input logic [W-1:0] seen,
		input logic [W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic summarize;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Wait for the rising edge that samples waitrequest low; read data
	// stands at that same edge, so it is taken there and nowhere else
	task automatic bus_wait(output logic [BUS_DW-1:0] d);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'h0 && n < 50);
		if (avs_waitrequest_o !== 1'h0) begin
			n_mismatch++;
		end
		d = avs_readdata_o;
	endtask

	// Register write over the slave bus
	task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [31:0] d);
		logic [BUS_DW-1:0] dummy;
		@(posedge clk_i);
		avs_address_i   <= a;
		avs_writedata_i <= d;
		avs_write_i     <= 1'h1;
		bus_wait(dummy);
		avs_write_i     <= 1'h0;
	endtask

	// Register read over the slave bus
	task automatic bus_rd(input logic [BUS_AW-1:0] a,
		output logic [BUS_DW-1:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i    <= 1'h1;
		bus_wait(d);
		avs_read_i    <= 1'h0;
	endtask

	// Control word: mode, output registers, flow-through, width codes
	function automatic logic [31:0] ctrl(input logic [1:0] m,
		input logic oa, ob, fl, input logic [1:0] wa, wb);
		return {23'h0, wb, wa, fl, ob, oa, m};
	endfunction

	// Byte-lane merge of a masked write
	function automatic logic [W-1:0] merge(input logic [W-1:0] o, n,
		input logic [NB-1:0] be);
		logic [W-1:0] m;
		m = '0;
		for (int i = 0; i < NB; i++) begin
			if (be[i]) m[i*LANE_BITS +: LANE_BITS] = '1;
		end
		return (o & ~m) | (n & m);
	endfunction

	// Step one edge and let its updates settle
	task automatic step;
		@(posedge clk_i);
		#1;
	endtask

	// Hang guard, well beyond the hundred or so cycles of the tests
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		summarize();
	end

	// Main sequence
	initial begin
		{resetn_i, iclr_i, oclr_i, avs_read_i, avs_write_i} = '0;
		{avs_address_i, avs_writedata_i, n_mismatch, samples_checked} = '0;
		ce_i = 1'h1;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'h1;
		#1;
		check("waitrequest", {35'h0, avs_waitrequest_o}, 36'h1);
		check("q_a reset", q_a_o, '0);
		bus_rd(REG_CTRL, rd);
		check("ctrl reset", {4'h0, rd}, 36'h0);
		bus_rd(REG_STATUS, rd);
		check("status kind", {4'h0, rd}, 36'h4);
		bus_wr(4'h8, 32'hffff_ffff);
		bus_rd(4'h8, rd);
		check("unmapped", {4'h0, rd}, 36'h0);
		bus_rd(REG_CTRL, rd);
		check("ctrl kept", {4'h0, rd}, 36'h0);
		// Single port, unregistered: written word shows one edge later
		fab.op(1'h1, 1'h0, 10'h005, D5, 4'hf, 1'h0, 1'h0, '0, '0);
		step();
		check("q_a single", q_a_o, D5);
		// Output register adds one cycle
		bus_wr(REG_CTRL, ctrl(2'h0, 1'h1, 1'h0, 1'h0, 2'h0, 2'h0));
		bus_rd(REG_CTRL, rd);
		check("ctrl oreg", {4'h0, rd}, 36'h4);
		fab.op(1'h1, 1'h0, 10'h006, D6, 4'hf, 1'h0, 1'h0, '0, '0);
		step();
		check("q_a oreg early", q_a_o, D5);
		step();
		check("q_a oreg", q_a_o, D6);
		// Byte enables keep lanes 0 and 2, ninth bits included
		bus_wr(REG_CTRL, 32'h0);
		fab.op(1'h1, 1'h0, 10'h006, '1, 4'ha, 1'h0, 1'h0, '0, '0);
		fab.op(1'h0, 1'h1, 10'h006, '0, 4'hf, 1'h0, 1'h0, '0, '0);
		step();
		exp6 = merge(D6, '1, 4'ha);
		check("q_a lanes", q_a_o, exp6);
		// Simple dual port, A writes a 9-bit sub-word while B reads
		bus_wr(REG_CTRL, ctrl(2'h1, 1'h0, 1'h0, 1'h0, 2'h2, 2'h0));
		fab.op(1'h1, 1'h0, 10'h01a, 36'h1a5, 4'hf,
			1'h0, 1'h1, 10'h005, '0);
		step();
		check("q_b same cycle", q_b_o, D5);
		fab.op(1'h0, 1'h0, '0, '0, 4'hf, 1'h0, 1'h1, 10'h006, '0);
		step();
		exp6 = {exp6[35:27], 9'h1a5, exp6[17:0]};
		check("q_b mixed", q_b_o, exp6);
		// True dual port: two writes, then two reads crossed over
		bus_wr(REG_CTRL, ctrl(2'h2, 1'h0, 1'h0, 1'h0, 2'h0, 2'h0));
		fab.op(1'h1, 1'h0, 10'h007, DA, 4'hf, 1'h1, 1'h0, 10'h008, DB);
		fab.op(1'h0, 1'h1, 10'h008, '0, 4'hf, 1'h0, 1'h1, 10'h007, '0);
		step();
		check("q_a dual", q_a_o, DB);
		check("q_b dual", q_b_o, DA);
		// Split: the same address on each port is a different memory
		bus_wr(REG_CTRL, ctrl(2'h3, 1'h0, 1'h0, 1'h0, 2'h0, 2'h0));
		fab.op(1'h1, 1'h0, 10'h003, D5, 4'hf, 1'h1, 1'h0, 10'h003, D6);
		fab.op(1'h0, 1'h1, 10'h003, '0, 4'hf, 1'h0, 1'h1, 10'h003, '0);
		step();
		check("q_a split", q_a_o, D5);
		check("q_b split", q_b_o, D6);
		bus_rd(REG_STATUS, rd);
		check("status split", {4'h0, rd}, 36'h4);
		// Flow-through: read data at the capturing edge itself
		bus_wr(REG_CTRL, ctrl(2'h1, 1'h0, 1'h1, 1'h1, 2'h0, 2'h0));
		fab.op(1'h0, 1'h0, '0, '0, 4'hf, 1'h0, 1'h1, 10'h007, '0);
		#1;
		check("q_b flow", q_b_o, DA);
		// Output clear acts with no clock edge
		@(posedge clk_i);
		oclr_i <= 1'h1;
		#1;
		check("q_a oclr", q_a_o, '0);
		check("q_b oclr", q_b_o, '0);
		@(posedge clk_i);
		oclr_i <= 1'h0;
		// Input clear held over a write keeps the write from landing
		bus_wr(REG_CTRL, 32'h0);
		@(posedge clk_i);
		iclr_i <= 1'h1;
		fab.op(1'h1, 1'h0, 10'h003, DB, 4'hf, 1'h0, 1'h0, '0, '0);
		@(posedge clk_i);
		iclr_i <= 1'h0;
		fab.op(1'h0, 1'h1, 10'h003, '0, 4'hf, 1'h0, 1'h0, '0, '0);
		step();
		check("q_a iclr", q_a_o, D5);
		// Clock enable low freezes the input registers: the write is lost
		@(posedge clk_i);
		ce_i <= 1'h0;
		fab.op(1'h1, 1'h0, 10'h003, DB, 4'hf, 1'h0, 1'h0, '0, '0);
		@(posedge clk_i);
		ce_i <= 1'h1;
		fab.op(1'h0, 1'h1, 10'h003, '0, 4'hf, 1'h0, 1'h0, '0, '0);
		step();
		check("q_a frozen", q_a_o, D5);
		summarize();
	end
endmodule
